/* hw/sas_pkg.sv */
// Constants and types shared by the converter sequencer files
package sas_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_MHZ   = 200;
    localparam int unsigned CONV_MAX_MHZ  = 18;
    localparam int unsigned CONV_DIV      = (SYS_CLK_MHZ + CONV_MAX_MHZ - 1) / CONV_MAX_MHZ;
    localparam int unsigned CONV_MIN_CLKS = 18;
    localparam int unsigned RES_W         = 12;
    localparam int unsigned CONV_TAIL     = RES_W + 2;
    localparam int unsigned SAMP_MIN      = CONV_MIN_CLKS - CONV_TAIL;

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    localparam int unsigned PIN_CH  = 8;
    localparam int unsigned MAX_CH  = 16;
    localparam logic [4:0]  MUX_TEMP = 5'h10;
    localparam logic [15:0] PIN_MASK = 16'h00ff;
    localparam logic [15:0] EXT_MASK = 16'hffff;

    // ------------------------------------------------------------
    // Register byte offsets and address page selects
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_INT_STAT = 8'h08;
    localparam logic [7:0] REG_INT_MASK = 8'h0c;
    localparam logic [7:0] REG_RANGE_LO = 8'h10;
    localparam logic [7:0] REG_RANGE_HI = 8'h14;
    localparam logic [7:0] REG_RANGE_CH = 8'h18;
    localparam logic [1:0] CH_CFG_PAGE  = 2'h1;
    localparam logic [1:0] RESULT_PAGE  = 2'h2;

    // ------------------------------------------------------------
    // Fields
    // ------------------------------------------------------------
    localparam int unsigned CTRL_EN     = 0;
    localparam int unsigned CTRL_START  = 1;
    localparam int unsigned CTRL_CONT   = 2;
    localparam int unsigned CTRL_MANUAL = 3;
    localparam int unsigned CTRL_MCH_LO = 4;
    localparam int unsigned CTRL_REF_LO = 8;
    localparam int unsigned CTRL_TEMP   = 10;
    localparam int unsigned CTRL_EXT    = 11;
    localparam int unsigned INT_RANGE   = 0;
    localparam int unsigned INT_EOS     = 1;
    localparam int unsigned INT_DONE    = 2;
    localparam int unsigned CFG_EN      = 0;
    localparam int unsigned CFG_SAMP_LO = 8;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [11:0] CTRL_RST     = 12'h000;
    localparam logic [7:0]  SAMP_RST     = 8'h04;
    localparam logic [11:0] RANGE_LO_RST = 12'h000;
    localparam logic [11:0] RANGE_HI_RST = 12'hfff;
    localparam logic [1:0]  REF_VDD      = 2'h0;
    localparam logic [1:0]  REF_HALF     = 2'h1;
    localparam logic [1:0]  REF_BGAP     = 2'h2;
    localparam logic [1:0]  REF_EXT      = 2'h3;

    typedef enum logic [1:0] {
        SAS_IDLE = 2'b00,
        SAS_RUN  = 2'b01
    } sas_seq_t;

    typedef enum logic [1:0] {
        SAS_C_IDLE = 2'b00,
        SAS_C_SAMP = 2'b01,
        SAS_C_CONV = 2'b11
    } sas_core_t;

endpackage

/* hw/sas_result_mem.sv */
// Per-channel result store with registered read port
`timescale 1ns/1ps
module sas_result_mem (
    input  wire logic        clk,
    input  wire logic        we,
    input  wire logic [3:0]  waddr,
    input  wire logic [11:0] wdata,
    input  wire logic [3:0]  raddr,
    output logic      [11:0] rdata_q
);

    logic [11:0] mem [0:15];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata_q <= mem[raddr];
    end

endmodule

/* hw/sas_sar_core.sv */
// Successive-approximation engine: sample window then twelve bit trials
`timescale 1ns/1ps
module sas_sar_core (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        tick,
    input  wire logic        abort,
    input  wire logic        go,
    input  wire logic [7:0]  samp_ticks,
    input  wire logic        cmp_in,
    output logic             sample_on,
    output logic             busy,
    output logic [11:0]      dac_code,
    output logic             done_q,
    output logic             chained_q,
    output logic [11:0]      result_q
);

    sas_pkg::sas_core_t state_q;
    logic [7:0]         cnt_q;
    logic [11:0]        sar_q;
    logic [7:0]         samp_load;
    logic [3:0]         bit_idx;
    logic               last_tick;

    assign samp_load = (samp_ticks < 8'(sas_pkg::SAMP_MIN)) ?
                       8'(sas_pkg::SAMP_MIN - 1) : samp_ticks - 8'h01;
    assign bit_idx   = 4'(cnt_q - 8'h02);
    assign last_tick = tick && (state_q == sas_pkg::SAS_C_CONV) && (cnt_q == 8'h00);
    assign sample_on = (state_q == sas_pkg::SAS_C_SAMP);
    assign busy      = (state_q != sas_pkg::SAS_C_IDLE);
    assign dac_code  = sar_q;

    // ------------------------------------------------------------
    // Conversion sequence
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= sas_pkg::SAS_C_IDLE;
            cnt_q   <= 8'h00;
            sar_q   <= 12'h000;
        end else if (abort) begin
            state_q <= sas_pkg::SAS_C_IDLE;
        end else if (tick) begin
            case (state_q)
                sas_pkg::SAS_C_IDLE: begin
                    if (go) begin
                        state_q <= sas_pkg::SAS_C_SAMP;
                        cnt_q   <= samp_load;
                    end
                end
                sas_pkg::SAS_C_SAMP: begin
                    if (cnt_q == 8'h00) begin
                        state_q <= sas_pkg::SAS_C_CONV;
                        cnt_q   <= 8'(sas_pkg::CONV_TAIL - 1);
                        sar_q   <= 12'h800;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                sas_pkg::SAS_C_CONV: begin
                    if (cnt_q >= 8'h02) begin
                        // Keep the trial bit only if the input is at or above the DAC level
                        sar_q[bit_idx] <= cmp_in;
                        if (bit_idx != 4'h0) begin
                            sar_q[bit_idx - 4'h1] <= 1'b1;
                        end
                    end
                    if (cnt_q == 8'h00) begin
                        // Chain straight into the next sample window, no idle tick
                        state_q <= go ? sas_pkg::SAS_C_SAMP : sas_pkg::SAS_C_IDLE;
                        cnt_q   <= samp_load;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: state_q <= sas_pkg::SAS_C_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_q    <= 1'b0;
            chained_q <= 1'b0;
            result_q  <= 12'h000;
        end else begin
            done_q <= last_tick && !abort;
            if (last_tick) begin
                chained_q <= go;
                result_q  <= sar_q;
            end
        end
    end

endmodule

/* hw/sas_top.sv */
// Converter channel sequencer with Avalon-MM register slave
// Function
// [RULE1] Twelve-bit result, at least eighteen converter clocks, converter clock at most 18 MHz.
// [RULE2] Next channel's sampling starts straight after the previous conversion, no idle.
// [RULE3] Eight pin channels, extendable to sixteen by a control bit. Manual mode here selects any of the sixteen without the bit.
// [RULE4] A started scan converts every enabled channel in turn unaided.
// [RULE5] Channel chosen by the sequencer or directly by firmware.
// [RULE6] Each channel keeps its own result register.
// [RULE7] Sample window programmable per channel and applied when that channel samples.
// [RULE8] Each result is checked against low and high bounds; outside raises interrupt.
// [RULE9] Out-of-range flag rises as the offending conversion completes.
// [RULE10] Reference select: supply, half supply, bandgap or external pin.
// [RULE11] Temperature sensor selectable as a converter input.
// [RULE12] No conversions while a low-power retention state is active.
// [RULE13] Out-of-range flag sticky until software clears it; maskable.
// [RULE14] End-of-scan event once the last enabled channel's result is stored.
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module sas_top (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    input  wire logic        lowpower,
    input  wire logic        cmp_in,
    output logic      [4:0]  mux_sel,
    output logic      [1:0]  ref_sel,
    output logic             sample_on,
    output logic      [11:0] dac_code
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    sas_pkg::sas_seq_t seq_q;
    logic [11:0]       ctrl_q;
    logic [2:0]        int_stat_q;
    logic [2:0]        int_mask_q;
    logic [11:0]       range_lo_q;
    logic [11:0]       range_hi_q;
    logic [15:0]       range_ch_q;
    logic [15:0]       cfg_en_q;
    logic [7:0]        cfg_samp_q [0:15];
    logic [3:0]        cur_ch_q;
    logic [4:0]        mux_sel_q;
    logic [3:0]        div_q;
    logic              tick_q;
    logic [1:0]        rd_stage_q;
    logic [31:0]       readdata_q;
    logic [31:0]       rd_word;
    logic              wr_ctrl;
    logic              start_req;
    logic              run_ok;
    logic [15:0]       scan_en;
    logic [4:0]        first_ch;
    logic [4:0]        next_ch;
    logic [4:0]        cont_ch;
    logic              has_next;
    logic              core_go;
    logic [3:0]        samp_ch;
    logic              core_busy;
    logic              done;
    logic              chained;
    logic [11:0]       result;
    logic              out_range;
    logic [11:0]       mem_rdata;
    logic [2:0]        int_set;
    logic [2:0]        int_clr;

    // Lowest enabled channel at or above 'from'; bit 4 set means none
    function automatic logic [4:0] sas_find(input logic [4:0] from, input logic [15:0] en);
        logic [4:0] res;
        res = 5'h10;
        for (int i = 15; i >= 0; i--) begin
            if ((5'(i) >= from) && en[i]) begin
                res = 5'(i);
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign avs_waitrequest = avs_read && (rd_stage_q != 2'h2);
    assign avs_readdata    = readdata_q;
    assign wr_ctrl         = avs_write && (avs_address == sas_pkg::REG_CTRL);
    // [RULE12] Blocked in low power
    assign run_ok          = ctrl_q[sas_pkg::CTRL_EN] && !lowpower;
    assign start_req       = wr_ctrl && avs_writedata[sas_pkg::CTRL_START] && run_ok;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_stage_q <= 2'h0;
            readdata_q <= 32'h0000_0000;
        end else if (avs_read) begin
            rd_stage_q <= (rd_stage_q == 2'h2) ? 2'h0 : rd_stage_q + 2'h1;
            if (rd_stage_q == 2'h1) begin
                readdata_q <= rd_word;
            end
        end else begin
            rd_stage_q <= 2'h0;
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        if (avs_address[7:6] == sas_pkg::RESULT_PAGE) begin
            rd_word = {20'h00000, mem_rdata};
        end else if (avs_address[7:6] == sas_pkg::CH_CFG_PAGE) begin
            rd_word = {16'h0000, cfg_samp_q[avs_address[5:2]], 7'h00,
                       cfg_en_q[avs_address[5:2]]};
        end else begin
            case (avs_address)
                sas_pkg::REG_CTRL:     rd_word = {20'h00000, ctrl_q};
                sas_pkg::REG_STATUS:   rd_word = {24'h000000, cur_ch_q, 1'b0, sample_on,
                                                  lowpower, seq_q == sas_pkg::SAS_RUN};
                sas_pkg::REG_INT_STAT: rd_word = {29'h00000000, int_stat_q};
                sas_pkg::REG_INT_MASK: rd_word = {29'h00000000, int_mask_q};
                sas_pkg::REG_RANGE_LO: rd_word = {20'h00000, range_lo_q};
                sas_pkg::REG_RANGE_HI: rd_word = {20'h00000, range_hi_q};
                sas_pkg::REG_RANGE_CH: rd_word = {16'h0000, range_ch_q};
                default:               rd_word = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q     <= sas_pkg::CTRL_RST;
            int_mask_q <= 3'h0;
            range_lo_q <= sas_pkg::RANGE_LO_RST;
            range_hi_q <= sas_pkg::RANGE_HI_RST;
        end else if (avs_write) begin
            case (avs_address)
                // Start is a one-shot and is never stored
                sas_pkg::REG_CTRL:     ctrl_q <= avs_writedata[11:0] & 12'hffd;
                // [RULE13] Interrupt mask
                sas_pkg::REG_INT_MASK: int_mask_q <= avs_writedata[2:0];
                // [RULE8] Bound registers
                sas_pkg::REG_RANGE_LO: range_lo_q <= avs_writedata[11:0];
                sas_pkg::REG_RANGE_HI: range_hi_q <= avs_writedata[11:0];
                default:               ctrl_q <= ctrl_q;
            endcase
        end
    end

    // [RULE7] Per-channel sample window
    for (genvar g = 0; g < sas_pkg::MAX_CH; g++) begin : g_ch
        always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
                cfg_en_q[g]   <= 1'b0;
                cfg_samp_q[g] <= sas_pkg::SAMP_RST;
            end else if (avs_write && (avs_address[7:6] == sas_pkg::CH_CFG_PAGE) &&
                         (avs_address[5:2] == 4'(g))) begin
                cfg_en_q[g]   <= avs_writedata[sas_pkg::CFG_EN];
                cfg_samp_q[g] <= avs_writedata[sas_pkg::CFG_SAMP_LO +: 8];
            end
        end
        // [RULE9] Per-channel out-of-range flag, set wins over clear
        always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
                range_ch_q[g] <= 1'b0;
            end else if (done && out_range && (cur_ch_q == 4'(g))) begin
                range_ch_q[g] <= 1'b1;
            end else if (avs_write && (avs_address == sas_pkg::REG_RANGE_CH) &&
                         avs_writedata[g]) begin
                range_ch_q[g] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Converter clock
    // ------------------------------------------------------------
    // [RULE1] Tick rate kept at or under the converter clock limit
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_q  <= 4'h0;
            tick_q <= 1'b0;
        end else if (!run_ok) begin
            div_q  <= 4'h0;
            tick_q <= 1'b0;
        end else begin
            div_q  <= (div_q == 4'(sas_pkg::CONV_DIV - 1)) ? 4'h0 : div_q + 4'h1;
            tick_q <= (div_q == 4'(sas_pkg::CONV_DIV - 1));
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // [RULE5] Manual mode converts the firmware-chosen channel only
    // [RULE3] Extension bit opens channels eight to fifteen to the scan; manual mode reaches them without it
    assign scan_en  = ctrl_q[sas_pkg::CTRL_MANUAL] ?
                      (16'h0001 << ctrl_q[sas_pkg::CTRL_MCH_LO +: 4]) :
                      (cfg_en_q & (ctrl_q[sas_pkg::CTRL_EXT] ? sas_pkg::EXT_MASK :
                                                             sas_pkg::PIN_MASK));
    assign first_ch = sas_find(5'h00, scan_en);
    assign next_ch  = sas_find({1'b0, cur_ch_q} + 5'h01, scan_en);
    assign cont_ch  = next_ch[4] ? first_ch : next_ch;
    assign has_next = !next_ch[4] ||
                      (ctrl_q[sas_pkg::CTRL_CONT] && !ctrl_q[sas_pkg::CTRL_MANUAL] &&
                       !first_ch[4]);
    // [RULE2] Next channel is offered during the last bit so sampling chains on
    assign core_go  = (seq_q == sas_pkg::SAS_RUN) && (!core_busy || has_next);
    assign samp_ch  = core_busy ? cont_ch[3:0] : cur_ch_q;

    // [RULE4] Autonomous stepping through the enabled set
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            seq_q    <= sas_pkg::SAS_IDLE;
            cur_ch_q <= 4'h0;
        end else if (!run_ok) begin
            seq_q <= sas_pkg::SAS_IDLE;
        end else begin
            case (seq_q)
                sas_pkg::SAS_IDLE: begin
                    if (start_req && !first_ch[4]) begin
                        seq_q    <= sas_pkg::SAS_RUN;
                        cur_ch_q <= first_ch[3:0];
                    end
                end
                sas_pkg::SAS_RUN: begin
                    if (done) begin
                        cur_ch_q <= cont_ch[3:0];
                        if (!chained) begin
                            seq_q <= sas_pkg::SAS_IDLE;
                        end
                    end
                end
                default: seq_q <= sas_pkg::SAS_IDLE;
            endcase
        end
    end

    // [RULE11] Top slot may be routed to the temperature sensor
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mux_sel_q <= 5'h00;
        end else if (ctrl_q[sas_pkg::CTRL_TEMP] && (cur_ch_q == 4'hf)) begin
            mux_sel_q <= sas_pkg::MUX_TEMP;
        end else begin
            // Follows the channel in conversion; only the window length looks ahead
            mux_sel_q <= {1'b0, cur_ch_q};
        end
    end

    assign mux_sel = mux_sel_q;
    // [RULE10] Reference choice driven straight from control
    assign ref_sel = ctrl_q[sas_pkg::CTRL_REF_LO +: 2];

    // ------------------------------------------------------------
    // Converter and result store
    // ------------------------------------------------------------
    sas_sar_core u_core (
        .clk        (sys_clk),
        .rst        (sys_rst),
        .tick       (tick_q),
        .abort      (!run_ok),
        .go         (core_go),
        .samp_ticks (cfg_samp_q[samp_ch]),
        .cmp_in     (cmp_in),
        .sample_on  (sample_on),
        .busy       (core_busy),
        .dac_code   (dac_code),
        .done_q     (done),
        .chained_q  (chained),
        .result_q   (result)
    );

    // [RULE6] One result slot per channel
    sas_result_mem u_mem (
        .clk     (sys_clk),
        .we      (done),
        .waddr   (cur_ch_q),
        .wdata   (result),
        .raddr   (avs_address[5:2]),
        .rdata_q (mem_rdata)
    );

    // [RULE8] Window compare on each fresh result
    assign out_range = (result < range_lo_q) || (result > range_hi_q);

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    // [RULE14] End of scan on the last enabled channel's store
    assign int_set = {done, done && next_ch[4], done && out_range};
    assign int_clr = (avs_write && (avs_address == sas_pkg::REG_INT_STAT)) ?
                     avs_writedata[2:0] : 3'h0;

    // [RULE13] Sticky until written with one; a new event wins
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            int_stat_q <= 3'h0;
        end else begin
            int_stat_q <= int_set | (int_stat_q & ~int_clr);
        end
    end

    assign irq = |(int_stat_q & int_mask_q);

endmodule

/* dv/sas_analog_model.sv */
// Analog front end model: channel levels, hold capacitor, comparator
`timescale 1ns/1ps
module sas_analog_model (
    input  wire logic        sys_clk,
    input  wire logic [11:0] base,
    input  wire logic [4:0]  mux_sel,
    input  wire logic        sample_on,
    input  wire logic [11:0] dac_code,
    output logic             cmp_in
);
    logic [11:0] held_q = 12'h000;
    // Level of input c is base plus c steps of 0xc0; slot 16 is the sensor
    always @(posedge sys_clk) begin
        if (sample_on) begin
            held_q <= base + 12'(mux_sel) * 12'h0c0;
        end
    end
    assign cmp_in = held_q >= dac_code;
endmodule

/* dv/sas_monitor.sv */
// Port assertions for the converter sequencer
`timescale 1ns/1ps
module sas_monitor (
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    input wire logic [7:0] avs_address,
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest,
    input wire logic       irq,
    input wire logic       lowpower,
    input wire logic [4:0] mux_sel,
    input wire logic [1:0] ref_sel,
    input wire logic       sample_on
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic [9:0] hi_q, lo_q;
    // Cycles in and out of the window; out-count saturates, starts full
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hi_q <= 10'h000;
            lo_q <= 10'h3ff;
        end else begin
            hi_q <= sample_on ? hi_q + 10'h001 : 10'h000;
            lo_q <= sample_on ? 10'h000 : lo_q + {9'h000, ~&lo_q};
        end
    end
    sequence s_rd_wait; avs_waitrequest [*2] ##1 !avs_waitrequest; endsequence
    sequence s_samp4; sample_on [*4]; endsequence
    property p_rd_wait; $rose(avs_read) |-> s_rd_wait; endproperty
    property p_wr_nowait; avs_write |-> !avs_waitrequest; endproperty
    property p_mux_rng; mux_sel <= 5'h10; endproperty
    property p_samp_len; $fell(sample_on) && !lowpower |-> hi_q >= 10'd47; endproperty
    property p_conv_gap; $rose(sample_on) |-> lo_q >= 10'd167; endproperty
    property p_ref_src;
        $changed(ref_sel) |-> $past(avs_write) && $past(avs_address[7:2]) == 6'h00;
    endproperty
    property p_irq_hold; irq && !avs_write |=> irq; endproperty
    property p_mux_hold; s_samp4 |-> $stable(mux_sel); endproperty
    property p_lp_idle; lowpower [*3] |-> !sample_on; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait");
    a_wr_nowait: assert property (p_wr_nowait) else $error("write wait");
    a_mux_rng: assert property (p_mux_rng) else $error("mux range");
    a_samp_len: assert property (p_samp_len) else $error("short window");
    a_conv_gap: assert property (p_conv_gap) else $error("short conversion");
    a_ref_src: assert property (p_ref_src) else $error("reference moved");
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
    a_mux_hold: assert property (p_mux_hold) else $error("mux moved");
    a_lp_idle: assert property (p_lp_idle) else $error("sampling in retention");
endmodule

bind sas_top sas_monitor u_sas_monitor (.sys_clk, .sys_rst, .avs_address, .avs_read,
    .avs_write, .avs_waitrequest, .irq, .lowpower, .mux_sel, .ref_sel, .sample_on);

/* dv/sas_top_test.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module sas_top_test;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic        lowpower = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0;
    logic [11:0] base = 12'h000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest, irq, cmp_in, sample_on;
    logic [4:0]  mux_sel;
    logic [1:0]  ref_sel;
    logic [11:0] dac_code;
    logic [31:0] exp_q[$];
    int          err_total = 0;
    int          checks_done = 0;

    always #2.5 sys_clk = ~sys_clk;

    sas_top u_sas_top (.sys_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .lowpower, .cmp_in,
        .mux_sel, .ref_sel, .sample_on, .dac_code);
    sas_analog_model u_sas_analog_model (.sys_clk, .base, .mux_sel, .sample_on,
        .dac_code, .cmp_in);

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checks_done++;
        if (got !== want) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        if (avs_read && !avs_waitrequest) begin
            chk(avs_readdata, exp_q.pop_front());
        end
    end

    // Read notes its expected data; both hold until waitrequest is low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        if (!wr) exp_q.push_back(d);
        avs_address <= a;
        avs_writedata <= wr ? d : 32'h0;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge sys_clk); while (avs_waitrequest);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wait_irq();
        for (int n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge sys_clk);
    endtask

    function automatic logic [31:0] lv(input logic [4:0] c);
        return {20'h0, base + 12'(c) * 12'h0c0};
    endfunction

    initial begin
        #60us;
        err_total++;
        test_done();
    end

    initial begin
        base <= 12'($urandom(44215)) & 12'h1ff;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        bus(0, 8'h00, 32'h0);
        bus(0, 8'h14, 32'hfff);
        bus(0, 8'h40, 32'h400);
        bus(1, 8'h3c, 32'hffffffff);
        bus(0, 8'h3c, 32'h0);
        bus(1, 8'h04, 32'hff);
        bus(0, 8'h04, 32'h0);
        $display("test reset done");
        bus(1, 8'h40, 32'h0401);
        bus(1, 8'h64, 32'h0801);
        bus(1, 8'h7c, 32'h1401);
        bus(1, 8'h10, lv(0));
        bus(1, 8'h14, lv(9) - 32'h1);
        bus(1, 8'h0c, 32'h1);
        // Start is only taken once enable already stands
        bus(1, 8'h00, 32'hc01);
        bus(1, 8'h00, 32'hc03);
        wait_irq();
        bus(0, 8'h18, 32'h0200);
        bus(0, 8'h08, 32'h5);
        bus(1, 8'h0c, 32'h2);
        wait_irq();
        chk({31'h0, irq}, 32'h1);
        bus(0, 8'h08, 32'h7);
        bus(0, 8'h18, 32'h8200);
        bus(0, 8'h80, lv(0));
        bus(0, 8'ha4, lv(9));
        bus(0, 8'hbc, lv(16));
        bus(1, 8'h0c, 32'h1);
        chk({31'h0, irq}, 32'h1);
        bus(1, 8'h08, 32'h7);
        chk({31'h0, irq}, 32'h0);
        $display("test scan done");
        bus(1, 8'h0c, 32'h2);
        for (int r = 0; r < 4; r++) begin
            base <= 12'($urandom) & 12'h1ff;
            bus(1, 8'h00, 32'h899 | (r << 8));
            bus(1, 8'h00, 32'h89b | (r << 8));
            wait_irq();
            chk({30'h0, ref_sel}, 32'(r));
            bus(0, 8'ha4, lv(9));
            bus(1, 8'h08, 32'h7);
        end
        $display("test manual done");
        bus(1, 8'h00, 32'h005);
        bus(1, 8'h00, 32'h007);
        wait_irq();
        bus(1, 8'h08, 32'h7);
        wait_irq();
        chk({31'h0, irq}, 32'h1);
        bus(1, 8'h00, 32'h001);
        repeat (300) @(posedge sys_clk);
        bus(0, 8'h04, 32'h0);
        bus(1, 8'h08, 32'h7);
        $display("test continuous done");
        lowpower <= 1'b1;
        bus(1, 8'h00, 32'h3);
        repeat (400) @(posedge sys_clk);
        bus(0, 8'h08, 32'h0);
        $display("test retention done");
        test_done();
    end
endmodule
